// ==== verilog/dsp_guard_pkg.sv ====
// shared constants for the processor run control and memory write guard
package dsp_guard_pkg;
   localparam int          ADDR_W        = 16;           // register address width
   localparam int          DATA_W        = 32;           // register data width
   localparam int          RAM_W         = 28;           // data memory word width
   localparam int          RAM_IDX_W     = 6;            // data memory index width
   localparam logic [15:0] RAM_FIRST     = 16'h4380;     // first data memory address
   localparam logic [15:0] RAM_LAST      = 16'h43be;     // last data memory address
   localparam int          RAM_DEPTH     = 63;           // locations in the window
   localparam logic [15:0] LOCK_CTRL_ADDR = 16'he7e3;    // lock control location
   localparam logic [15:0] LOCK_KEY_ADDR = 16'he7fe;     // key location
   localparam logic [15:0] RUN_ADDR      = 16'he228;     // processor run register
   localparam logic [15:0] EVT_FLAG_ADDR = 16'he502;     // first event flag register
   localparam logic [15:0] EVT_EN_ADDR   = 16'he50a;     // first event enable register
   localparam logic [15:0] SOFT_RST_ADDR = 16'he618;     // software reset register
   localparam int          SOFT_RST_BIT  = 7;            // software reset trigger bit
   localparam int          DONE_BIT      = 17;           // computation-done position
   localparam logic [7:0]  KEY_VALUE     = 8'had;        // unlock key
   localparam logic [7:0]  LOCK_ON       = 8'h80;        // lock control: protect
   localparam logic [7:0]  LOCK_OFF      = 8'h00;        // lock control: release
   localparam logic [15:0] RUN_RESET     = 16'h0000;     // run register reset value
   localparam logic [15:0] RUN_GO        = 16'h0001;     // run register start value
   localparam logic [15:0] RUN_HALT      = 16'h0000;     // run register stop value
   localparam int          CLK_HZ        = 100000000;    // core clock rate
   localparam int          CYCLE_HZ      = 8000;         // computation repetition rate
   localparam int          CYCLE_CLKS    = CLK_HZ / CYCLE_HZ; // clocks per computation
   // host command codes
   typedef enum logic [2:0] {
      OP_READ  = 3'b000,
      OP_WRITE = 3'b001,
      OP_RAMWR = 3'b010,
      OP_LOCK  = 3'b011,
      OP_UNLOCK = 3'b100,
      OP_START = 3'b101,
      OP_STOP  = 3'b110
   } host_op_t;
endpackage

// ==== verilog/reg_link_if.sv ====
// parallel register port between host and metering device, one clock
`timescale 1ns/100ps
interface reg_link_if (
   input wire logic clk
);
   import dsp_guard_pkg::*;
   logic              req;          // host holds a request until ack
   logic              we;           // request is a write
   logic [ADDR_W-1:0] addr;         // register address
   logic [DATA_W-1:0] wdata;        // write data
   logic [DATA_W-1:0] rdata;        // read data, valid with ack
   logic              ack;          // one-cycle answer
   logic              evt_req_n;    // first event request pin, active low

   modport device (input clk, input req, input we, input addr, input wdata,
                   output rdata, output ack, output evt_req_n);
   modport host   (input clk, output req, output we, output addr, output wdata,
                   input rdata, input ack, input evt_req_n);
endinterface

// ==== verilog/dsp_guard_dev.sv ====
// device end: processor run control, event flag and guarded data memory
// Functional notes
// [RULE1] running processor computes once per 8 kHz
// [RULE2] end of computation sets done flag bit17
// [RULE3] enabled done flag drives request pin low
// [RULE4] writing one to bit17 clears flag, pin
// [RULE5] memory window 0x4380..0x43be, 28-bit words
// [RULE6] window writes pass two-stage pipeline
// [RULE7] after reset idle, memory zero, accessible
// [RULE8] run resets zero; one starts processor
// [RULE9] writing zero to run halts processor
// [RULE10] lock off at reset; locked writes ignored
// [RULE11] window reads always return data
// [RULE12] key then 0x80 at control locks
// [RULE13] key then 0x00 at control unlocks
// [RULE14] host locks before starting processor
// [RULE15] memory updates accepted while running
// [RULE16] host bring-up: init, lock, verify, run
// [RULE17] restart: run again, or reset first
// [RULE18] host stops processor before leaving full power
// [RULE19] lock changes only right after key
`timescale 1ns/100ps
module dsp_guard_dev #(
   parameter int CYCLE_CLKS_P = dsp_guard_pkg::CYCLE_CLKS   // clocks per computation
) (
   input wire logic         rstn,
   reg_link_if.device       link,
   output logic             running,
   output logic             locked,
   output logic             done_pulse
);
   import dsp_guard_pkg::*;

   logic                 clk;              // core clock from the link
   logic                 take;             // request accepted this cycle
   logic                 wr;               // accepted write
   logic                 in_ram;           // address inside the window
   logic [RAM_IDX_W-1:0] idx;              // window index of the address
   logic                 ram_wr;           // window write that is not blocked
   logic                 soft_rst;         // software reset strobe
   logic [15:0]          run_r;            // processor run register
   logic                 lock_r;           // write protection state
   logic                 key_ok_r;         // previous write was the correct key
   logic [31:0]          cnt_r;            // computation cycle counter
   logic                 tick;             // end of a computation
   logic                 flag_r;           // computation-done flag
   logic                 flag_nxt;
   logic [DATA_W-1:0]    en_r;             // first event enable register
   logic                 evt_n_r;          // request pin flop
   logic                 ack_r;
   logic [DATA_W-1:0]    rdata_r;
   logic [DATA_W-1:0]    rd_nxt;
   logic                 done_r;
   // two pipeline stages ahead of the memory
   logic                 s1_v_r, s2_v_r;
   logic [RAM_IDX_W-1:0] s1_i_r, s2_i_r;
   logic [RAM_W-1:0]     s1_d_r, s2_d_r;
   logic [RAM_W-1:0]     ram_r [RAM_DEPTH];

   assign clk  = link.clk;
   // one request taken per handshake; ack masks the still-held req
   assign take = link.req && !ack_r;
   assign wr   = take && link.we;
   assign in_ram = (link.addr >= RAM_FIRST) && (link.addr <= RAM_LAST);   // RULE5
   assign idx    = RAM_IDX_W'(link.addr - RAM_FIRST);
   assign ram_wr = wr && in_ram && !lock_r;   // RULE10
   assign soft_rst = wr && (link.addr == SOFT_RST_ADDR) && link.wdata[SOFT_RST_BIT];
   assign tick = run_r[0] && (cnt_r == 32'(CYCLE_CLKS_P - 1));

   // run register: reset, soft reset, start and halt
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_r <= RUN_RESET;   // RULE8
      end else if (soft_rst) begin
         run_r <= RUN_RESET;   // RULE7
      end else if (wr && link.addr == RUN_ADDR) begin
         // any value is stored; only bit 0 decides execution
         run_r <= link.wdata[15:0];   // RULE8 RULE9
      end
   end

   // computation timer; restarts from zero on every start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 32'h0000_0000;
      end else if (!run_r[0] || tick) begin
         cnt_r <= 32'h0000_0000;   // RULE1
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   // done flag: a new completion beats a same-cycle clear
   always_comb begin
      flag_nxt = flag_r;
      if (wr && link.addr == EVT_FLAG_ADDR && link.wdata[DONE_BIT]) begin
         flag_nxt = 1'b0;   // RULE4
      end
      if (soft_rst) begin
         flag_nxt = 1'b0;
      end
      if (tick) begin
         flag_nxt = 1'b1;   // RULE2
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_r  <= 1'b0;
         evt_n_r <= 1'b1;
         done_r  <= 1'b0;
      end else begin
         flag_r  <= flag_nxt;
         // pin falls with the flag while enable bit17 is set, and rises when flag or enable clears
         evt_n_r <= !(flag_nxt && en_r[DONE_BIT]);   // RULE3 RULE4
         done_r  <= tick;
      end
   end

   // event enable register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_r <= 32'h0000_0000;
      end else if (soft_rst) begin
         en_r <= 32'h0000_0000;
      end else if (wr && link.addr == EVT_EN_ADDR) begin
         en_r <= link.wdata;
      end
   end

   // key tracker: only the very next write may use the key
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         key_ok_r <= 1'b0;
      end else if (soft_rst) begin
         key_ok_r <= 1'b0;
      end else if (wr) begin
         key_ok_r <= (link.addr == LOCK_KEY_ADDR) && (link.wdata[7:0] == KEY_VALUE);   // RULE19
      end
   end

   // protection state; unknown control values leave it alone
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_r <= 1'b0;   // RULE10
      end else if (soft_rst) begin
         lock_r <= 1'b0;
      end else if (wr && link.addr == LOCK_CTRL_ADDR && key_ok_r) begin
         if (link.wdata[7:0] == LOCK_ON) begin
            lock_r <= 1'b1;   // RULE12
         end else if (link.wdata[7:0] == LOCK_OFF) begin
            lock_r <= 1'b0;   // RULE13
         end
      end
   end

   // write pipeline: a value lands only after two further window writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_v_r <= 1'b0;
         s2_v_r <= 1'b0;
         s1_i_r <= '0;
         s2_i_r <= '0;
         s1_d_r <= '0;
         s2_d_r <= '0;
      end else if (soft_rst) begin
         s1_v_r <= 1'b0;
         s2_v_r <= 1'b0;
      end else if (ram_wr) begin
         // accepted regardless of run state, so updates work live
         s1_v_r <= 1'b1;   // RULE6 RULE15
         s1_i_r <= idx;
         s1_d_r <= link.wdata[RAM_W-1:0];
         s2_v_r <= s1_v_r;
         s2_i_r <= s1_i_r;
         s2_d_r <= s1_d_r;
      end
   end

   // memory words, one flop group per location
   for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_ram
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            ram_r[g] <= '0;   // RULE7
         end else if (soft_rst) begin
            ram_r[g] <= '0;
         end else if (ram_wr && s2_v_r && s2_i_r == RAM_IDX_W'(g)) begin
            ram_r[g] <= s2_d_r;   // RULE6
         end
      end
   end

   // read multiplexer; unmapped and write-only addresses read zero
   always_comb begin
      rd_nxt = '0;
      if (in_ram) begin
         rd_nxt = {{(DATA_W-RAM_W){1'b0}}, ram_r[idx]};   // RULE11
      end else if (link.addr == RUN_ADDR) begin
         rd_nxt = {16'h0000, run_r};
      end else if (link.addr == EVT_FLAG_ADDR) begin
         rd_nxt = DATA_W'(flag_r) << DONE_BIT;
      end else if (link.addr == EVT_EN_ADDR) begin
         rd_nxt = en_r;
      end
   end

   // answer one cycle after the request is taken
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_r   <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= take;
         if (take && !link.we) begin
            rdata_r <= rd_nxt;
         end
      end
   end

   assign link.ack       = ack_r;
   assign link.rdata     = rdata_r;
   assign link.evt_req_n = evt_n_r;
   assign running        = run_r[0];
   assign locked         = lock_r;
   assign done_pulse     = done_r;
endmodule

// ==== verilog/dsp_guard_host.sv ====
// host end: turns user commands into register sequences on the link
`timescale 1ns/100ps
module dsp_guard_host (
   input wire logic                          rstn,
   reg_link_if.host                          link,
   input wire logic                          cmd_valid,
   input wire dsp_guard_pkg::host_op_t       cmd_op,
   input wire logic [dsp_guard_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [dsp_guard_pkg::DATA_W-1:0] cmd_wdata,
   output logic                              cmd_ready,
   output logic                              rsp_valid,
   output logic [dsp_guard_pkg::DATA_W-1:0]  rsp_rdata,
   output logic                              event_seen
);
   import dsp_guard_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_BUSY = 2'b01,
      H_DONE = 2'b10
   } host_state_t;

   logic              clk;          // core clock from the link
   host_state_t       st_r;         // sequencer state
   host_op_t          op_r;         // command being run
   logic [ADDR_W-1:0] caddr_r;      // command address
   logic [DATA_W-1:0] cdata_r;      // command data
   logic [1:0]        step_r;       // step within the sequence
   logic [1:0]        last;         // final step of the command
   logic              req_r, we_r;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wdata_r, wdata_nxt;
   logic              we_nxt;
   logic              rsp_r;
   logic [DATA_W-1:0] rdata_r;
   logic              evt_r;

   assign clk = link.clk;

   // address and data for each step of each command
   always_comb begin
      addr_nxt  = caddr_r;
      wdata_nxt = cdata_r;
      we_nxt    = 1'b1;
      last      = 2'd0;
      case (op_r)
         OP_READ: begin
            we_nxt = 1'b0;
         end
         OP_RAMWR: begin
            last = 2'd2;   // RULE6
         end
         OP_LOCK, OP_UNLOCK, OP_START: begin
            last      = (op_r == OP_START) ? 2'd2 : 2'd1;
            addr_nxt  = LOCK_KEY_ADDR;
            wdata_nxt = {24'h00_0000, KEY_VALUE};
            if (step_r == 2'd1) begin
               addr_nxt  = LOCK_CTRL_ADDR;
               wdata_nxt = {24'h00_0000, (op_r == OP_UNLOCK) ? LOCK_OFF : LOCK_ON};   // RULE12 RULE13
            end else if (step_r == 2'd2) begin
               // protection goes on before the processor starts
               addr_nxt  = RUN_ADDR;
               wdata_nxt = {16'h0000, RUN_GO};   // RULE14 RULE16 RULE17
            end
         end
         OP_STOP: begin
            addr_nxt  = RUN_ADDR;
            wdata_nxt = {16'h0000, RUN_HALT};   // RULE18
         end
         default: begin
         end
      endcase
   end

   // sequencer: one link transfer per step, waiting for each ack
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r    <= H_IDLE;
         op_r    <= OP_READ;
         caddr_r <= '0;
         cdata_r <= '0;
         step_r  <= 2'd0;
         req_r   <= 1'b0;
         we_r    <= 1'b0;
         addr_r  <= '0;
         wdata_r <= '0;
         rsp_r   <= 1'b0;
         rdata_r <= '0;
      end else begin
         rsp_r <= 1'b0;
         case (st_r)
            H_IDLE: begin
               if (cmd_valid) begin
                  op_r    <= cmd_op;
                  caddr_r <= cmd_addr;
                  cdata_r <= cmd_wdata;
                  step_r  <= 2'd0;
                  st_r    <= H_DONE;
               end
            end
            H_DONE: begin
               // launch the current step
               req_r   <= 1'b1;
               we_r    <= we_nxt;
               addr_r  <= addr_nxt;
               wdata_r <= wdata_nxt;
               st_r    <= H_BUSY;
            end
            H_BUSY: begin
               if (link.ack) begin
                  req_r <= 1'b0;
                  if (step_r == last) begin
                     rsp_r   <= 1'b1;
                     rdata_r <= link.rdata;
                     st_r    <= H_IDLE;
                  end else begin
                     step_r <= step_r + 2'd1;
                     st_r   <= H_DONE;
                  end
               end
            end
            default: begin
               st_r <= H_IDLE;
            end
         endcase
      end
   end

   // event pin seen low, same clock so no synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         evt_r <= 1'b0;
      end else begin
         evt_r <= !link.evt_req_n;
      end
   end

   assign link.req   = req_r;
   assign link.we    = we_r;
   assign link.addr  = addr_r;
   assign link.wdata = wdata_r;
   assign cmd_ready  = (st_r == H_IDLE);
   assign rsp_valid  = rsp_r;
   assign rsp_rdata  = rdata_r;
   assign event_seen = evt_r;
endmodule

// ==== testbench/dsp_guard_properties.sv ====
// concurrent checks on the register link and the device status outputs
`timescale 1ns/100ps
module dsp_guard_properties #(
   parameter int CYCLE_CLKS_P = dsp_guard_pkg::CYCLE_CLKS   // clocks per computation
) (
   input wire logic                              clk,
   input wire logic                              rstn,
   input wire logic                              req,
   input wire logic                              we,
   input wire logic [dsp_guard_pkg::ADDR_W-1:0]  addr,
   input wire logic [dsp_guard_pkg::DATA_W-1:0]  wdata,
   input wire logic [dsp_guard_pkg::DATA_W-1:0]  rdata,
   input wire logic                              ack,
   input wire logic                              evt_req_n,
   input wire logic                              running,
   input wire logic                              locked,
   input wire logic                              done_pulse
);
   import dsp_guard_pkg::*;
   logic [31:0] gap_r;     // clocks since the last completion
   logic        gap_ok_r;  // a full gap is being measured
   logic        take;      // device takes a request at this edge
   logic        in_win;    // address inside the memory window
   assign take   = req && !ack;
   assign in_win = addr >= RAM_FIRST && addr <= RAM_LAST;
   // gap counter, restarted when idle so a stop never looks like a short cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_r    <= '0;
         gap_ok_r <= 1'b0;
      end else if (!running) begin
         gap_r    <= '0;
         gap_ok_r <= 1'b0;
      end else begin
         gap_r    <= done_pulse ? '0 : gap_r + 32'h1;
         gap_ok_r <= gap_ok_r || done_pulse;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   done_gap_a: assert property (done_pulse && gap_ok_r |-> gap_r == CYCLE_CLKS_P - 1)
      else $error("completion spacing wrong");
   done_run_a: assert property (done_pulse |-> running || $past(running))
      else $error("completion while halted");
   // pin falls with the completion pulse, or one cycle after an enable write
   pin_cause_a: assert property ($fell(evt_req_n) |-> done_pulse || $past(ack))
      else $error("request pin fell without cause");
   pin_clear_a: assert property (take && we && addr == EVT_FLAG_ADDR && wdata[DONE_BIT]
      |-> ##[1:3] (evt_req_n || done_pulse))
      else $error("request pin not released");
   read_answer_a: assert property (take && !we && in_win |=> ack)
      else $error("window read not answered");
   read_pad_a: assert property (ack && !we && in_win |-> rdata[DATA_W-1:RAM_W] == '0)
      else $error("window read not zero padded");
   // state flops change at the take edge, so the answer stands beside the new value
   lock_cause_a: assert property ($changed(locked) |-> ack && (addr == LOCK_CTRL_ADDR
      || addr == SOFT_RST_ADDR))
      else $error("lock state changed without control write");
   run_cause_a: assert property ($changed(running) |-> ack && (addr == RUN_ADDR
      || addr == SOFT_RST_ADDR))
      else $error("run state changed without run write");
   idle_reset_a: assert property ($rose(rstn) |-> !running && !done_pulse && evt_req_n)
      else $error("device not idle after reset");
   // main scenarios reached
   cover property (done_pulse);
   cover property ($rose(locked));
   cover property ($fell(evt_req_n));
   cover property ($fell(running));
endmodule

// ==== testbench/dsp_run_and_ram_write_guard_test.sv ====
// self-checking bench: host end drives the device end across the register link
`timescale 1ns/100ps
module dsp_run_and_ram_write_guard_test;
   import dsp_guard_pkg::*;
   localparam int CYC = 200;                // shortened computation period
   typedef struct packed {
      logic [DATA_W-1:0] mask;              // bits compared, zero for none
      logic [DATA_W-1:0] val;               // expected response data
   } note_t;
   logic              clk = 1'b0;           // 100 MHz core clock
   logic              rstn = 1'b0;          // async reset, active low
   logic              cmd_valid = 1'b0;     // command request
   host_op_t          cmd_op = OP_READ;     // command code
   logic [ADDR_W-1:0] cmd_addr = '0;        // command address
   logic [DATA_W-1:0] cmd_wdata = '0;       // command data
   logic              cmd_ready;            // host end idle
   logic              rsp_valid;            // command finished
   logic [DATA_W-1:0] rsp_rdata;            // last read data
   logic              event_seen;           // request pin seen low
   logic              running;              // processor running
   logic              locked;               // window protected
   logic              done_pulse;           // computation end
   logic [DATA_W-1:0] v [4];                // random test words
   logic [ADDR_W-1:0] a;                    // random window address
   note_t             notes[$];             // expected responses, oldest first
   note_t             cur;                  // note being compared
   int                fail_count = 0;
   int                cmp_count = 0;
   always #5 clk = ~clk;
   reg_link_if link (.clk(clk));
   dsp_guard_dev #(.CYCLE_CLKS_P(CYC)) u_dsp_guard_dev (.rstn(rstn), .link(link),
      .running(running), .locked(locked), .done_pulse(done_pulse));
   dsp_guard_host u_dsp_guard_host (.rstn(rstn), .link(link), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .event_seen(event_seen));
   dsp_guard_properties #(.CYCLE_CLKS_P(CYC)) u_dsp_guard_properties (.clk(clk),
      .rstn(rstn), .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
      .rdata(link.rdata), .ack(link.ack), .evt_req_n(link.evt_req_n), .running(running),
      .locked(locked), .done_pulse(done_pulse));
   // masked compare, x never matches
   task automatic check(input logic [DATA_W-1:0] got, exp, m, input string what);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, exp, input string what);
      check({31'b0, got}, {31'b0, exp}, 32'h1, what);
   endtask
   // window word as stored: upper bits dropped
   function automatic logic [DATA_W-1:0] w28(input logic [DATA_W-1:0] x);
      return {{(DATA_W-RAM_W){1'b0}}, x[RAM_W-1:0]};
   endfunction
   // one host command: note the expectation, hand over, wait for completion
   task automatic cmd(input host_op_t op, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] d, m, e);
      int n;
      notes.push_back('{m, e});
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_addr  <= ad;
      cmd_wdata <= d;
      do @(negedge clk); while (!cmd_ready);
      @(posedge clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!rsp_valid && n < 300);
      if (!rsp_valid) begin
         fail_count++;
         $display("wrong value at %0t: command never finished", $time);
      end
   endtask
   task automatic wr(input host_op_t op, input logic [ADDR_W-1:0] ad,
                     input logic [DATA_W-1:0] d);
      cmd(op, ad, d, '0, '0);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
      cmd(OP_READ, ad, '0, '1, e);
   endtask
   // response watcher: oldest note against each completion
   always @(negedge clk) begin
      if (rsp_valid && notes.size() > 0) begin
         cur = notes.pop_front();
         if (cur.mask !== '0) begin
            check(rsp_rdata, cur.val, cur.mask, "response data");
         end
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog, well beyond the expected run of about a thousand clocks
   initial begin
      #100000;
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end
   initial begin
      void'($urandom(32'h2561));
      for (int i = 0; i < 4; i++) v[i] = $urandom;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      cmd(OP_READ, RUN_ADDR, '0, 32'hffff, {16'h0, RUN_RESET});
      rd(RAM_FIRST, '0);
      chk1(running, 1'b0, "running");
      chk1(locked, 1'b0, "locked");
      $display("test reset state done");
      wr(OP_WRITE, RAM_FIRST, v[0]);
      wr(OP_WRITE, RAM_FIRST + 16'h1, v[1]);
      rd(RAM_FIRST, '0);
      wr(OP_RAMWR, RAM_LAST, v[2]);
      rd(RAM_FIRST, w28(v[0]));
      rd(RAM_FIRST + 16'h1, w28(v[1]));
      rd(RAM_LAST, w28(v[2]));
      wr(OP_RAMWR, RAM_LAST + 16'h1, v[3]);
      rd(RAM_LAST + 16'h1, '0);
      $display("test pipeline done");
      wr(OP_LOCK, '0, '0);
      chk1(locked, 1'b1, "locked");
      wr(OP_RAMWR, RAM_FIRST, v[3]);
      rd(RAM_FIRST, w28(v[0]));
      rd(LOCK_KEY_ADDR, '0);
      wr(OP_WRITE, LOCK_KEY_ADDR, 32'(KEY_VALUE));
      wr(OP_WRITE, 16'h0000, '0);
      wr(OP_WRITE, LOCK_CTRL_ADDR, 32'(LOCK_OFF));
      chk1(locked, 1'b1, "locked");
      wr(OP_WRITE, LOCK_KEY_ADDR, 32'h12);
      wr(OP_WRITE, LOCK_CTRL_ADDR, 32'(LOCK_OFF));
      chk1(locked, 1'b1, "locked");
      wr(OP_UNLOCK, '0, '0);
      chk1(locked, 1'b0, "locked");
      $display("test lock done");
      wr(OP_WRITE, EVT_EN_ADDR, 32'h1 << DONE_BIT);
      wr(OP_START, '0, '0);
      chk1(running, 1'b1, "running");
      for (int i = 0; i < 2 * CYC && !event_seen; i++) @(negedge clk);
      chk1(link.evt_req_n, 1'b0, "request pin");
      cmd(OP_READ, EVT_FLAG_ADDR, '0, 32'h1 << DONE_BIT, 32'h1 << DONE_BIT);
      wr(OP_WRITE, EVT_FLAG_ADDR, 32'h1 << DONE_BIT);
      chk1(link.evt_req_n, 1'b1, "request pin");
      wr(OP_UNLOCK, '0, '0);
      wr(OP_RAMWR, RAM_FIRST, v[3]);
      wr(OP_LOCK, '0, '0);
      rd(RAM_FIRST, w28(v[3]));
      wr(OP_STOP, '0, '0);
      chk1(running, 1'b0, "running");
      repeat (2 * CYC) @(negedge clk);
      chk1(link.evt_req_n, 1'b1, "request pin");
      wr(OP_WRITE, RUN_ADDR, 32'(RUN_GO));
      chk1(running, 1'b1, "running");
      $display("test run control done");
      wr(OP_WRITE, SOFT_RST_ADDR, 32'h1 << SOFT_RST_BIT);
      repeat (2) @(negedge clk);
      chk1(running, 1'b0, "running");
      chk1(locked, 1'b0, "locked");
      rd(RAM_FIRST, '0);
      for (int i = 0; i < 4; i++) begin
         a = RAM_FIRST + 16'($urandom_range(0, RAM_DEPTH - 1));
         wr(OP_RAMWR, a, v[i]);
         rd(a, w28(v[i]));
      end
      $display("test soft reset done");
      print_verdict();
   end
endmodule
